// ---- verilog/fcd_pkg.sv ----
// package for the flash command front end: command codes, status bits, sizes
// assumes a 16-bit data bus and a word address bus from the parallel flash port
package fcd_pkg;
	// command codes seen on the data bus
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK = 8'h01;
	localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
	localparam logic [7:0] CMD_PROT_SETUP = 8'hc0;
	localparam logic [7:0] CMD_CFG_LOAD = 8'h03;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	// status word bit positions
	localparam int SB_READY = 7;
	localparam int SB_ESUSP = 6;
	localparam int SB_ERASE = 5;
	localparam int SB_PROG = 4;
	localparam int SB_PSUSP = 2;
	localparam int SB_LOCKED = 1;
	localparam logic [7:0] STATUS_RESET = 8'h80;
	// sizes
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int BLK_W = 6;
	localparam int NBLK = 64;
	localparam int BLK_LSB = 16;
	localparam int CFG_LSB_WIDE = 1;
	localparam logic [15:0] CFG_RESET = 16'hbfcf;
	localparam logic [1:0] LOCK_RESET = 2'h1;
	// algorithm duration in cycles of the sequencer, kept short
	localparam int ALG_CYCLES = 16;
	localparam logic [7:0] APB_ID = 8'h5a; // arbitrary value
	// register offsets on the APB side
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_CONFIG = 12'h004;
	localparam logic [11:0] OFS_LOCK = 12'h008;
	localparam logic [11:0] OFS_IRQ = 12'h00c;
	localparam logic [11:0] OFS_MASK = 12'h010;
	localparam logic [11:0] OFS_ID = 12'h014;
	// operation codes handed to the sequencer
	typedef enum logic [1:0]
	{
		OP_PROGRAM = 2'b00,
		OP_ERASE = 2'b01,
		OP_PROT = 2'b10
	} fcd_op_e;
endpackage : fcd_pkg

// ---- verilog/fcd_seq_if.sv ----
// link between the command front end and the algorithm sequencer
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface fcd_seq_if;
	logic start;
	fcd_pkg::fcd_op_e op;
	logic suspend;
	logic resume;
	logic busy;
	logic suspended;
	logic done;
	modport front (output start, output op, output suspend, output resume,
		input busy, input suspended, input done);
	modport seq (input start, input op, input suspend, input resume,
		output busy, output suspended, output done);
endinterface : fcd_seq_if
`default_nettype wire

// ---- verilog/fcd_seq.sv ----
// on-chip algorithm sequencer: times program, erase and protection writes
// assumes one start at a time from the front end
`timescale 1ns/100ps
`default_nettype none
module fcd_seq
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	fcd_seq_if.seq sq
);
	logic [4:0] cnt_q;
	logic run_q;
	logic susp_q;
	logic done_q;

	// countdown, held while suspended
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 5'h00;
			run_q <= 1'b0;
			susp_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (ce)
		begin
			done_q <= 1'b0;
			if (sq.start && !run_q)
			begin
				run_q <= 1'b1;
				cnt_q <= 5'(fcd_pkg::ALG_CYCLES);
			end
			else if (run_q && sq.suspend && !susp_q)
				susp_q <= 1'b1;
			else if (run_q && sq.resume && susp_q)
				susp_q <= 1'b0;
			else if (run_q && !susp_q)
			begin
				if (cnt_q == 5'h01)
				begin
					run_q <= 1'b0;
					done_q <= 1'b1;
				end
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end

	assign sq.busy = run_q && !susp_q;
	assign sq.suspended = susp_q;
	assign sq.done = done_q;
endmodule : fcd_seq
`default_nettype wire

// ---- verilog/fcd_front.sv ----
// command front end of a parallel flash: decodes bus-write command cycles
// assumes bus writes are single-cycle strobes from logic on CORE_CLK; APB for status
`timescale 1ns/100ps
`default_nettype none
module fcd_front
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic WR_STB,
	input wire logic [22:0] WR_ADDR,
	input wire logic [15:0] WR_DATA,
	input wire logic CFG_WIDE_PKG,
	input wire logic [11:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic READ_ARRAY,
	output logic [7:0] STATUS_WORD,
	output logic [15:0] READ_CONFIG_WORD,
	output logic PROT_WR,
	output logic [22:0] PROT_ADDR,
	output logic [15:0] PROT_DATA,
	output logic IRQ
);
	// sequence states; a setup code waits here for the very next bus write,
	// which either completes its sequence or is flagged as a sequence error

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_LOCK_ARMED = 3'b001,
		ST_PROT_ARMED = 3'b010,
		ST_PROG_ARMED = 3'b011,
		ST_ERASE_ARMED = 3'b100
	} fcd_state_e;

	fcd_seq_if sq ();
	fcd_state_e state_q;
	logic [7:0] status_q;
	logic [15:0] cfg_q;
	logic [1:0] lock_q [fcd_pkg::NBLK];
	logic read_array_q;
	logic start_q;
	fcd_pkg::fcd_op_e op_q;
	logic susp_req_q;
	logic resume_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic prot_wr_q;
	logic [22:0] prot_addr_q;
	logic [15:0] prot_data_q;
	logic irq_q;
	logic [7:0] cmd;
	logic [fcd_pkg::BLK_W-1:0] blk;
	logic seq_err;
	logic locked_hit;
	logic apb_acc;
	logic apb_done;
	logic stat_rd;

	// decode of the current bus write; only the low byte carries a code,
	// the upper byte is ignored so a host may leave it at any value;
	// the block index comes from the upper word address bits
	assign cmd = WR_DATA[7:0];
	assign blk = WR_ADDR[fcd_pkg::BLK_LSB +: fcd_pkg::BLK_W];
	// one setup code serves both lock and configuration sequences,
	// so the load code counts as a legal partner of a lock setup too
	assign seq_err = WR_STB &&
		((state_q == ST_LOCK_ARMED && cmd != fcd_pkg::CMD_LOCK
		&& cmd != fcd_pkg::CMD_CONFIRM && cmd != fcd_pkg::CMD_LOCK_DOWN
		&& cmd != fcd_pkg::CMD_CFG_LOAD)
		|| ((state_q == ST_ERASE_ARMED) && cmd != fcd_pkg::CMD_CONFIRM));
	assign locked_hit = lock_q[blk][0];
	assign apb_acc = PSEL && PENABLE && !pready_q;
	// completing edge: the master samples PREADY high here
	assign apb_done = PSEL && PENABLE && pready_q;
	assign stat_rd = apb_acc && !PWRITE && PADDR == fcd_pkg::OFS_IRQ;

	// sequencer on the same clock and enable, so its strobes need no crossing
	fcd_seq u_seq
	(
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.ce(CE),
		.sq(sq)
	);

	// one-cycle strobes; the sequencer only honours start while idle
	assign sq.start = start_q;
	assign sq.op = op_q;
	assign sq.suspend = susp_req_q;
	assign sq.resume = resume_q;

	// command state: one armed setup at a time, cleared after any second cycle
	// program and erase setups arm only while the sequencer is free
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			state_q <= ST_IDLE;
		else if (CE && WR_STB)
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (cmd == fcd_pkg::CMD_LOCK_SETUP)
						state_q <= ST_LOCK_ARMED;
					else if (cmd == fcd_pkg::CMD_PROT_SETUP)
						state_q <= ST_PROT_ARMED;
					else if (cmd == fcd_pkg::CMD_PROGRAM && !sq.busy && !sq.suspended)
						state_q <= ST_PROG_ARMED;
					else if (cmd == fcd_pkg::CMD_ERASE_SETUP && !sq.busy && !sq.suspended)
						state_q <= ST_ERASE_ARMED;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// sequencer launch, suspend and resume strobes
	// a program or erase on a locked block never starts; status bit 1 tells why
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			start_q <= 1'b0;
			op_q <= fcd_pkg::OP_PROGRAM;
			susp_req_q <= 1'b0;
			resume_q <= 1'b0;
			prot_wr_q <= 1'b0;
			prot_addr_q <= 23'h000000;
			prot_data_q <= 16'h0000;
		end
		else if (CE)
		begin
			start_q <= 1'b0;
			susp_req_q <= 1'b0;
			resume_q <= 1'b0;
			prot_wr_q <= 1'b0;
			if (WR_STB)
			begin
				if (state_q == ST_PROT_ARMED)
				begin
					prot_wr_q <= 1'b1;
					prot_addr_q <= WR_ADDR;
					prot_data_q <= WR_DATA;
					start_q <= 1'b1;
					op_q <= fcd_pkg::OP_PROT;
				end
				else if (state_q == ST_PROG_ARMED && !locked_hit)
				begin
					start_q <= 1'b1;
					op_q <= fcd_pkg::OP_PROGRAM;
				end
				else if (state_q == ST_ERASE_ARMED && cmd == fcd_pkg::CMD_CONFIRM && !locked_hit)
				begin
					start_q <= 1'b1;
					op_q <= fcd_pkg::OP_ERASE;
				end
				else if (state_q == ST_IDLE && cmd == fcd_pkg::CMD_SUSPEND && sq.busy)
					susp_req_q <= 1'b1;
				else if (state_q == ST_IDLE && cmd == fcd_pkg::CMD_CONFIRM && sq.suspended)
					resume_q <= 1'b1;
			end
		end
	end

	// block protection: bit 0 locked, bit 1 locked down; lock-down sticks until reset
	// software has no way back from lock-down, only reset clears bit 1
	generate
		for (genvar b = 0; b < fcd_pkg::NBLK; b++)
		begin : g_blk
			always_ff @(posedge CORE_CLK or negedge RSTN)
			begin
				if (!RSTN)
					lock_q[b] <= fcd_pkg::LOCK_RESET;
				else if (CE && WR_STB && state_q == ST_LOCK_ARMED && blk == b)
				begin
					if (cmd == fcd_pkg::CMD_LOCK)
						lock_q[b][0] <= 1'b1;
					else if (cmd == fcd_pkg::CMD_CONFIRM && !lock_q[b][1])
						lock_q[b][0] <= 1'b0;
					else if (cmd == fcd_pkg::CMD_LOCK_DOWN)
						lock_q[b] <= 2'h3;
				end
			end
		end
	endgenerate

	// read configuration word and array-read mode
	// any other write leaves array mode so the next read returns status
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			cfg_q <= fcd_pkg::CFG_RESET;
			read_array_q <= 1'b1;
		end
		else if (CE && WR_STB)
		begin
			if (state_q == ST_LOCK_ARMED && cmd == fcd_pkg::CMD_CFG_LOAD)
			begin
				cfg_q <= CFG_WIDE_PKG ? WR_ADDR[16:1] : WR_ADDR[15:0];
				read_array_q <= 1'b1;
			end
			else if (state_q == ST_IDLE && cmd == fcd_pkg::CMD_READ_ARRAY)
				read_array_q <= 1'b1;
			else
				read_array_q <= 1'b0; // other sequences return status
		end
	end

	// status word; error bits stick until clear status, set wins over clear
	// ready lags the sequencer by a cycle; start_q covers the gap before busy
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			status_q <= fcd_pkg::STATUS_RESET;
		else if (CE)
		begin
			status_q[fcd_pkg::SB_READY] <= !sq.busy && !start_q;
			status_q[fcd_pkg::SB_PSUSP] <= sq.suspended && op_q == fcd_pkg::OP_PROGRAM;
			status_q[fcd_pkg::SB_ESUSP] <= sq.suspended && op_q == fcd_pkg::OP_ERASE;
			if (seq_err)
			begin
				status_q[fcd_pkg::SB_ERASE] <= 1'b1;
				status_q[fcd_pkg::SB_PROG] <= 1'b1;
			end
			else if (WR_STB && state_q != ST_IDLE && locked_hit
				&& (state_q == ST_PROG_ARMED || state_q == ST_ERASE_ARMED))
				status_q[fcd_pkg::SB_LOCKED] <= 1'b1;
			else if (WR_STB && state_q == ST_IDLE && cmd == fcd_pkg::CMD_CLEAR_STATUS)
			begin
				status_q[fcd_pkg::SB_ERASE] <= 1'b0;
				status_q[fcd_pkg::SB_PROG] <= 1'b0;
				status_q[fcd_pkg::SB_LOCKED] <= 1'b0;
			end
		end
	end

	// sticky interrupt events: 0 seq error, 1 algorithm done, 2 suspend, 3 lock refused
	// events are single-cycle strobes, so the or keeps them until read
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			irq_stat_q <= 4'h0;
		else if (CE)
		begin
			// a new event in the clearing read cycle survives
			irq_stat_q <= (stat_rd ? 4'h0 : irq_stat_q) | {
				WR_STB && locked_hit && (state_q == ST_PROG_ARMED || state_q == ST_ERASE_ARMED),
				susp_req_q, sq.done, seq_err};
		end
	end

	// apb slave: one wait state, every access answers in the second access cycle;
	// read data are captured a cycle before the master takes them, while a write
	// only lands at the edge where the master sees PREADY high
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (CE)
		begin
			pready_q <= apb_acc;
			pslverr_q <= 1'b0;
			if (apb_acc)
			begin
				prdata_q <= 32'h00000000;
				if (PADDR == fcd_pkg::OFS_STATUS)
					prdata_q <= {24'h000000, status_q};
				else if (PADDR == fcd_pkg::OFS_CONFIG)
					prdata_q <= {16'h0000, cfg_q};
				else if (PADDR == fcd_pkg::OFS_LOCK)
					prdata_q <= {30'h00000000, lock_q[PADDR[7:2] ^ PWDATA[5:0]]};
				else if (PADDR == fcd_pkg::OFS_IRQ)
					prdata_q <= {28'h0000000, irq_stat_q};
				else if (PADDR == fcd_pkg::OFS_MASK)
					prdata_q <= {28'h0000000, irq_mask_q};
				else if (PADDR == fcd_pkg::OFS_ID)
					prdata_q <= {24'h000000, fcd_pkg::APB_ID};
				else
					pslverr_q <= 1'b1; // unmapped
			end
		end
	end

	// interrupt mask, written at the completing edge of the transfer only
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			irq_mask_q <= 4'h0;
		else if (CE && apb_done && PWRITE && PADDR == fcd_pkg::OFS_MASK)
			irq_mask_q <= PWDATA[3:0];
	end

	// registered copies for the top-level outputs
	// every pin comes straight from a flip-flop, so no decode glitch escapes
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			irq_q <= 1'b0;
		else if (CE)
			irq_q <= |(irq_stat_q & irq_mask_q);
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign READ_ARRAY = read_array_q;
	assign STATUS_WORD = status_q;
	assign READ_CONFIG_WORD = cfg_q;
	assign PROT_WR = prot_wr_q;
	assign PROT_ADDR = prot_addr_q;
	assign PROT_DATA = prot_data_q;
	assign IRQ = irq_q;
endmodule : fcd_front
`default_nettype wire

// ---- tb/fcd_front_monitor.sv ----
// checker on the command front end ports
// assumes no program or erase setup lands inside another sequence
`timescale 1ns/100ps
`default_nettype none
module fcd_front_monitor
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic WR_STB,
	input wire logic [22:0] WR_ADDR,
	input wire logic [15:0] WR_DATA,
	input wire logic CFG_WIDE_PKG,
	input wire logic [7:0] STATUS_WORD,
	input wire logic [15:0] READ_CONFIG_WORD,
	input wire logic READ_ARRAY,
	input wire logic PROT_WR,
	input wire logic [22:0] PROT_ADDR,
	input wire logic [15:0] PROT_DATA
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);
	logic acc;
	logic [7:0] cd;
	logic pend_q, lk_q, pc_q;
	assign acc = CE && WR_STB;
	assign cd = WR_DATA[7:0];
	// shadow of the armed setup; any write after a setup closes it
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pend_q <= 1'b0;
			lk_q <= 1'b0;
			pc_q <= 1'b0;
		end
		else if (acc)
		begin
			pend_q <= !pend_q && (cd inside {8'h60, 8'hc0, 8'h40, 8'h20});
			lk_q <= !pend_q && cd == 8'h60;
			pc_q <= !pend_q && cd == 8'hc0;
		end
	end
	property p_seq_err;
		acc && lk_q && !(cd inside {8'h01, 8'hd0, 8'h2f, 8'h03})
		|=> STATUS_WORD[7] && STATUS_WORD[5] && STATUS_WORD[4];
	endproperty
	a_seq_err: assert property (p_seq_err) else $error("no sequence error");
	property p_prot;
		acc && pc_q |=> PROT_WR && PROT_ADDR == $past(WR_ADDR) && PROT_DATA == $past(WR_DATA);
	endproperty
	a_prot: assert property (p_prot) else $error("protection write lost");
	property p_prot_src;
		PROT_WR |-> $past(acc) && $past(pc_q);
	endproperty
	a_prot_src: assert property (p_prot_src) else $error("stray protection write");
	property p_cfg;
		acc && lk_q && cd == 8'h03 |=> READ_CONFIG_WORD ==
			($past(CFG_WIDE_PKG) ? $past(WR_ADDR[16:1]) : $past(WR_ADDR[15:0]));
	endproperty
	a_cfg: assert property (p_cfg) else $error("config word wrong");
	property p_cfg_hold;
		!acc |=> $stable(READ_CONFIG_WORD);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config word moved");
	property p_array;
		acc && lk_q && cd == 8'h03 |-> ##[1:2] READ_ARRAY;
	endproperty
	a_array: assert property (p_array) else $error("no array reads");
	property p_susp;
		STATUS_WORD[2] |-> STATUS_WORD[7];
	endproperty
	a_susp: assert property (p_susp) else $error("suspend without ready");
	property p_resume;
		STATUS_WORD[2] && acc && cd == 8'hd0 && !pend_q |-> ##[1:3] !STATUS_WORD[2];
	endproperty
	a_resume: assert property (p_resume) else $error("resume ignored");
endmodule : fcd_front_monitor
bind fcd_front fcd_front_monitor fcd_front_monitor_inst (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
	.CE(CE), .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
	.CFG_WIDE_PKG(CFG_WIDE_PKG), .STATUS_WORD(STATUS_WORD),
	.READ_CONFIG_WORD(READ_CONFIG_WORD), .READ_ARRAY(READ_ARRAY), .PROT_WR(PROT_WR),
	.PROT_ADDR(PROT_ADDR), .PROT_DATA(PROT_DATA));
`default_nettype wire

// ---- tb/fcd_host_model.sv ----
// host side of the command bus: single write cycles
// assumes the front end takes a write at a rising edge with the strobe high
`timescale 1ns/100ps
`default_nettype none
module fcd_host_model
(
	input wire logic clk,
	output logic stb,
	output logic [22:0] addr,
	output logic [15:0] data
);
	// idle bus at time zero
	initial
	begin
		stb = 1'b0;
		addr = 23'h0;
		data = 16'h0;
	end
	// released lines show the inverse, so stale data never looks valid
	task automatic wr(input logic [22:0] a, input logic [15:0] d);
		@(posedge clk);
		stb <= 1'b1;
		addr <= a;
		data <= d;
		@(posedge clk);
		stb <= 1'b0;
		addr <= ~a;
		data <= ~d;
	endtask : wr
endmodule : fcd_host_model
`default_nettype wire

// ---- tb/test_flash_lock_config_cmd_decoder.sv ----
// self-checking bench for the flash command front end
// assumes the host model drives commands and this module the APB side
`timescale 1ns/100ps
`default_nettype none
module test_flash_lock_config_cmd_decoder;
	logic clk, rstn, ce, wide, psel, penable, pwrite, pready, pslverr, ra, pw, irq, stb, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] sw;
	logic [15:0] rcw, pd, wd;
	logic [22:0] pa, wa;
	int fail_count = 0;
	int cmp_count = 0;
	// code, block, status, lock state
	logic [31:0] rows [7] = '{32'hd0038000, 32'h01038001, 32'h2f058003, 32'hd0058003,
		32'h03078001, 32'hff07b001, 32'h4007b001};
	fcd_front fcd_front_inst (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .WR_STB(stb), .WR_ADDR(wa),
		.WR_DATA(wd), .CFG_WIDE_PKG(wide), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.READ_ARRAY(ra), .STATUS_WORD(sw), .READ_CONFIG_WORD(rcw), .PROT_WR(pw),
		.PROT_ADDR(pa), .PROT_DATA(pd), .IRQ(irq));
	fcd_host_model fcd_host_model_inst (.clk(clk), .stb(stb), .addr(wa), .data(wd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// setup code, second cycle, then time for the status to land
	task automatic seq(input logic [15:0] s, input logic [15:0] d, input logic [22:0] a);
		fcd_host_model_inst.wr(23'h7fffff, s);
		fcd_host_model_inst.wr(a, d);
		repeat (2) @(posedge clk);
	endtask : seq
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// a hang ends here; the tests need well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		fail_count++;
		complete_run();
	end
	initial
	begin
		rstn = 1'b0;
		ce = 1'b1;
		wide = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i])
		begin
			seq(16'h60, {8'h00, rows[i][31:24]}, {1'b0, rows[i][21:16], 16'h4c2d});
			chk(sw, rows[i][15:8]);
			// lock index is address word bits xor write data, so undo the 2 of 0x008
			apb(12'h008, 1'b0, {26'h0, rows[i][21:16]} ^ 32'h2);
			chk(r, rows[i][7:0]);
			if (rows[i][31:24] == 8'h03)
				chk(ra, 1'b1);
			fcd_host_model_inst.wr(23'h0, 16'h50);
		end
		chk(rcw, 16'h4c2d);
		// wide package takes address 16:1; a failed setup leaves nothing armed
		wide <= 1'b1;
		seq(16'h60, 16'h03, 23'h01abcd);
		chk(rcw, 16'hd5e6);
		wide <= 1'b0;
		seq(16'h60, 16'hff, 23'h0);
		seq(16'h60, 16'h03, 23'h000777);
		chk(rcw, 16'h0777);
		chk(sw, 8'hb0);
		fcd_host_model_inst.wr(23'h0, 16'h50);
		seq(16'hc0, 16'hbeef, 23'h012345);
		chk(pa, 23'h012345);
		chk(pd, 16'hbeef);
		repeat (40) @(posedge clk);
		// suspend a running program, resume it from another address
		seq(16'h60, 16'hd0, 23'h000000);
		seq(16'h40, 16'h1234, 23'h000010);
		fcd_host_model_inst.wr(23'h000020, 16'hb0);
		repeat (3) @(posedge clk);
		chk(sw, 8'h84);
		fcd_host_model_inst.wr(23'h400000, 16'hd0);
		repeat (3) @(posedge clk);
		chk(sw[2], 1'b0);
		repeat (40) @(posedge clk);
		chk(sw, 8'h80);
		// erase: suspend shows bit 6, resume clears it; then program refusal and bad erase confirm
		seq(16'h20, 16'hd0, 23'h000030);
		fcd_host_model_inst.wr(23'h000020, 16'hb0);
		repeat (3) @(posedge clk);
		chk(sw, 8'hc0);
		fcd_host_model_inst.wr(23'h000000, 16'hd0);
		repeat (3) @(posedge clk);
		chk(sw[6], 1'b0);
		repeat (40) @(posedge clk);
		seq(16'h40, 16'h1234, 23'h070000);
		chk(sw, 8'h82);
		seq(16'h20, 16'hff, 23'h000000);
		chk(sw, 8'hb2);
		fcd_host_model_inst.wr(23'h0, 16'h50);
		// interrupt raised, cleared by reading, then masked
		apb(12'h00c, 1'b0, 32'h0);
		apb(12'h010, 1'b1, 32'h1);
		seq(16'h60, 16'hff, 23'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		apb(12'h00c, 1'b0, 32'h0);
		chk(r, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		apb(12'h010, 1'b1, 32'h0);
		seq(16'h60, 16'h60, 23'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		apb(12'h014, 1'b0, 32'h0);
		chk(r, fcd_pkg::APB_ID);
		apb(12'h020, 1'b0, 32'h0);
		chk(e, 1'b1);
		// reset in mid-run restores status, config and block locks
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(sw, fcd_pkg::STATUS_RESET);
		chk(rcw, fcd_pkg::CFG_RESET);
		apb(12'h008, 1'b0, 32'h5 ^ 32'h2);
		chk(r, fcd_pkg::LOCK_RESET);
		complete_run();
	end
endmodule : test_flash_lock_config_cmd_decoder
`default_nettype wire
